// *** design/bps_pkg.sv ***
// Constants, types and field layout of the buck power sequencer.
package bps_pkg;

  // ==========================================================================
  // Register map and fields
  localparam logic [3:0]  ADDR_SETUP   = 4'h0;   // Setup bank 0
  localparam logic [3:0]  ADDR_EXT     = 4'h4;   // Extended setup
  localparam logic [3:0]  ADDR_STATUS  = 4'h8;   // Read-only status
  localparam int          SETUP_A_OFF  = 7;      // 1 holds channel A off
  localparam int          SETUP_B_ON   = 8;      // Channel B enable
  localparam int          SETUP_C_ON   = 9;      // Channel C enable
  localparam int          SETUP_LIN_ON = 10;     // Linear regulator enable
  localparam int          EXT_MASK_C   = 8;      // Reset mask channel C
  localparam int          EXT_MASK_B   = 9;      // Reset mask channel B
  localparam int          EXT_MASK_A   = 10;     // Reset mask channel A
  localparam int          EXT_MASK_LIN = 11;     // Reset mask linear reg
  localparam int          EXT_THERM0   = 13;     // Thermal control bit 0
  localparam int          EXT_THERM1   = 14;     // Thermal control bit 1
  localparam int          EXT_MOTOR    = 15;     // Motor fault release bit
  localparam logic [15:0] SETUP_RESET  = 16'h0080;
  localparam logic [15:0] EXT_RESET    = 16'h0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [1:0]  RESP_DECERR  = 2'h3;

  // ==========================================================================
  // Start select codes
  localparam logic [1:0]  SEL_GND      = 2'h0;
  localparam logic [1:0]  SEL_PULLDOWN = 2'h1;
  localparam logic [1:0]  SEL_OPEN     = 2'h2;

  // ==========================================================================
  // Timing
  localparam int CLK_KHZ      = 50000;           // 50 MHz clock
  localparam int CP_WAIT_MS   = 12;              // Inside 10..20 ms window
  localparam int C_DELAY_MS   = 10;
  localparam int PG_REG_MS    = 120;
  localparam int PG_GND_MS    = 300;
  localparam int PULSE_MS     = 40;
  localparam int LIN_MASK_MS  = 1;
  localparam int DEGLITCH_NS  = 5000;            // Inside 2.5..7.5 us
  localparam int CP_WAIT_CYC  = CP_WAIT_MS * CLK_KHZ;
  localparam int C_DELAY_CYC  = C_DELAY_MS * CLK_KHZ;
  localparam int PG_REG_CYC   = PG_REG_MS * CLK_KHZ;
  localparam int PG_GND_CYC   = PG_GND_MS * CLK_KHZ;
  localparam int PULSE_CYC    = PULSE_MS * CLK_KHZ;
  localparam int LIN_MASK_CYC = LIN_MASK_MS * CLK_KHZ;
  localparam logic [7:0] DEGLITCH_CYC = 8'((DEGLITCH_NS * CLK_KHZ + 999999) / 1000000);

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {st_off, st_cp_wait, st_start_c, st_pg_wait, st_run} bps_state_type;

  typedef struct packed {
    logic       thermal_shutdown;  // Thermal shutdown detected
    logic       motor_oc;          // Motor overcurrent
    logic       lin_oc;            // Linear regulator overcurrent
    logic [2:0] buck_oc;           // Per channel, index 0 is A
    logic [2:0] buck_ov;
    logic [2:0] buck_uv;
  } bps_fault_type;

  typedef struct packed {
    logic [2:0] buck_en;           // Index 0 A, 1 B, 2 C
    logic       linear_regulator;  // Linear regulator enable
    logic       charge_pump;
    logic       motor_oscillator;
    logic       motor_en;
  } bps_out_type;

endpackage : bps_pkg

// *** design/bps_sequencer.sv ***
// Power sequencer and protection logic for three bucks and one linear regulator.
module bps_sequencer
  import bps_pkg::*;
#(
  parameter int CP_WAIT_N  = CP_WAIT_CYC,
  parameter int C_DELAY_N  = C_DELAY_CYC,
  parameter int PG_REG_N   = PG_REG_CYC,
  parameter int PG_GND_N   = PG_GND_CYC,
  parameter int PULSE_N    = PULSE_CYC,
  parameter int LIN_MASK_N = LIN_MASK_CYC
) (
  // Clock and power-on reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // AXI4-Lite slave
  input  wire logic [3:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [3:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Supply comparators
  input  wire logic          supply_above_upper,
  input  wire logic          supply_above_lower,
  // Host pins
  input  wire logic [1:0]    start_select_pin,
  input  wire logic          system_clear_in_n,
  input  wire logic          sleep_ctrl_n,
  input  wire logic          chan_a_inhibit,
  // Fault detectors
  input  wire bps_fault_type faults,
  // Regulator and motor controls
  output bps_out_type        pwr_out,
  output logic               power_good_reset_out_n,
  output logic               sleep_int_n
);

  // ==========================================================================
  // Declarations
  bps_state_type state;            // Sequencer state
  logic [23:0]   seq_cnt;          // Sequencing delay counter
  logic [23:0]   pulse_cnt;        // Reset pulse counter
  logic [23:0]   lin_mask_cnt;     // Linear overcurrent mask counter
  logic [7:0]    dg_cnt;           // Clear deglitch counter
  logic          clear_f;          // Filtered clear, 1 released
  logic          vm_up;            // Supply hysteresis state
  logic          sel_b;            // Captured select wants B
  logic          sel_c;            // Captured select wants C
  logic          seq_b;            // Sequencer enabled B
  logic          seq_c;            // Sequencer enabled C
  logic [15:0]   setup;            // Setup bank 0
  logic [15:0]   ext;              // Extended setup
  logic          setup_written;    // Setup takes over enables
  logic [2:0]    chan_off;         // Per-channel fault latches
  logic          lin_off;          // Linear regulator fault latch
  logic          hard_off;         // Global shutdown latch
  logic          motor_stop;       // Motors stopped by fault
  logic          sleep_d;          // Previous sleep pin
  bps_out_type   next_out;         // Next regulator controls
  logic          next_reset_n;     // Next reset output
  logic          soft_rst;         // Supply low or clear held
  logic          sleep_rise;       // Sleep pin low to high
  logic          band;             // Between thresholds
  logic [2:0]    buck_flt;         // Qualified buck faults
  logic [2:0]    mask_vec;         // Reset masks A, B, C
  logic          lin_flt;          // Qualified linear fault
  logic          therm_hard;       // Thermal code latches
  logic          hard_evt;         // Event for global shutdown
  logic          motor_evt;        // Event that stops motors
  logic          pulse_evt;        // Event that pulses reset
  logic [2:0]    src;              // Requested buck enables
  logic          wr_go;            // Write handshake
  logic          wr_ok;            // Setup writes allowed
  logic [15:0]   status;           // Status word

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    merge = old;
    if (strb[0]) begin
      merge[7:0] = d[7:0];
    end
    if (strb[1]) begin
      merge[15:8] = d[15:8];
    end
  endfunction : merge

  // ==========================================================================
  // Supply and clear conditioning
  // Hysteresis: up above upper, down below lower
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vm_up <= 1'b0;
    end else if (!supply_above_lower) begin
      vm_up <= 1'b0;
    end else if (supply_above_upper) begin
      vm_up <= 1'b1;
    end
  end

  // Clear flips only after staying changed for the filter time
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clear_f <= 1'b1;
      dg_cnt  <= 8'h00;
    end else if (system_clear_in_n == clear_f) begin
      dg_cnt <= 8'h00;
    end else if (dg_cnt == DEGLITCH_CYC - 8'h01) begin
      clear_f <= system_clear_in_n;
      dg_cnt  <= 8'h00;
    end else begin
      dg_cnt <= dg_cnt + 8'h01;
    end
  end

  // Supply loss or held clear restarts everything
  assign soft_rst = !vm_up || !clear_f;

  // Sleep edge detector
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_d <= 1'b1;
    end else begin
      sleep_d <= sleep_ctrl_n;
    end
  end
  assign sleep_rise = sleep_ctrl_n && !sleep_d;

  // ==========================================================================
  // Start-up sequencer
  // Capture select, wait for pump unless select is grounded, stagger B and C, then release reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state   <= st_off;
      seq_cnt <= 24'h000000;
      sel_b   <= 1'b0;
      sel_c   <= 1'b0;
      seq_b   <= 1'b0;
      seq_c   <= 1'b0;
    end else if (soft_rst) begin
      state <= st_off;
      seq_b <= 1'b0;
      seq_c <= 1'b0;
    end else begin
      unique case (state)
        st_off: begin
          // Capture on supply rise or clear release
          sel_b <= (start_select_pin != SEL_GND);
          sel_c <= (start_select_pin == SEL_OPEN);
          if (start_select_pin == SEL_GND) begin
            state   <= st_pg_wait;
            seq_cnt <= 24'(PG_GND_N - 1);
          end else begin
            state   <= st_cp_wait;
            seq_cnt <= 24'(CP_WAIT_N - 1);
          end
        end
        st_cp_wait: begin
          if (seq_cnt == 24'h000000) begin
            seq_b <= sel_b;
            if (sel_c) begin
              state   <= st_start_c;
              seq_cnt <= 24'(C_DELAY_N - 1);
            end else begin
              state   <= st_pg_wait;
              seq_cnt <= 24'(PG_REG_N - 1);
            end
          end else begin
            seq_cnt <= seq_cnt - 24'h000001;
          end
        end
        st_start_c: begin
          if (seq_cnt == 24'h000000) begin
            seq_c   <= 1'b1;
            state   <= st_pg_wait;
            seq_cnt <= 24'(PG_REG_N - 1);
          end else begin
            seq_cnt <= seq_cnt - 24'h000001;
          end
        end
        st_pg_wait: begin
          if (seq_cnt == 24'h000000) begin
            state <= st_run;
          end else begin
            seq_cnt <= seq_cnt - 24'h000001;
          end
        end
        st_run: begin
          state <= st_run;
        end
      endcase
    end
  end

  // ==========================================================================
  // Fault qualification
  always_comb begin
    band       = supply_above_lower && !supply_above_upper;
    mask_vec   = {ext[EXT_MASK_C], ext[EXT_MASK_B], ext[EXT_MASK_A]};
    // Over/undervoltage ignored inside the hysteresis band
    buck_flt   = pwr_out.buck_en & (faults.buck_oc |
                 ((faults.buck_ov | faults.buck_uv) & {3{!band}}));
    lin_flt    = faults.lin_oc && pwr_out.linear_regulator &&
                 (lin_mask_cnt == 24'h000000);
    therm_hard = (ext[EXT_THERM1] == ext[EXT_THERM0]);
    hard_evt   = |(buck_flt & ~mask_vec) ||
                 (lin_flt && !ext[EXT_MASK_LIN]) ||
                 (faults.motor_oc && ext[EXT_MOTOR]) ||
                 (faults.thermal_shutdown && therm_hard);
    motor_evt  = faults.motor_oc || faults.thermal_shutdown;
    pulse_evt  = !motor_stop && ((faults.motor_oc && !ext[EXT_MOTOR]) ||
                 (faults.thermal_shutdown && ext[EXT_THERM1] && !ext[EXT_THERM0]));
  end

  // Global shutdown holds until supply reset or clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hard_off <= 1'b0;
    end else if (soft_rst) begin
      hard_off <= 1'b0;
    end else if (hard_evt && state == st_run) begin
      hard_off <= 1'b1;
    end
  end

  // Selective and motor latches; a new fault beats the sleep release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chan_off   <= 3'h0;
      lin_off    <= 1'b0;
      motor_stop <= 1'b0;
    end else if (soft_rst) begin
      chan_off   <= 3'h0;
      lin_off    <= 1'b0;
      motor_stop <= 1'b0;
    end else begin
      chan_off   <= (sleep_rise ? 3'h0 : chan_off) | (buck_flt & mask_vec);
      lin_off    <= (lin_off && !sleep_rise) || (lin_flt && ext[EXT_MASK_LIN]);
      motor_stop <= (motor_stop && !sleep_rise) || motor_evt;
    end
  end

  // Reset-output pulse timer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pulse_cnt <= 24'h000000;
    end else if (soft_rst) begin
      pulse_cnt <= 24'h000000;
    end else if (pulse_evt) begin
      pulse_cnt <= 24'(PULSE_N);
    end else if (pulse_cnt != 24'h000000) begin
      pulse_cnt <= pulse_cnt - 24'h000001;
    end
  end

  // Linear overcurrent mask restarts on each turn-on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lin_mask_cnt <= 24'h000000;
    end else if (next_out.linear_regulator && !pwr_out.linear_regulator) begin
      lin_mask_cnt <= 24'(LIN_MASK_N);
    end else if (lin_mask_cnt != 24'h000000) begin
      lin_mask_cnt <= lin_mask_cnt - 24'h000001;
    end
  end

  // ==========================================================================
  // Output decode
  always_comb begin
    // B and C select-driven until setup written, then bank 0; A always from bank 0
    src[0] = !setup[SETUP_A_OFF] && !chan_a_inhibit;
    src[1] = setup_written ? setup[SETUP_B_ON] : seq_b;
    src[2] = setup_written ? setup[SETUP_C_ON] : seq_c;
    next_out.buck_en = src & ~chan_off & {3{state != st_off && !hard_off}};
    // Linear regulator follows B during power-up
    if (state == st_run) begin
      next_out.linear_regulator = setup[SETUP_LIN_ON] && !lin_off && !hard_off;
    end else begin
      next_out.linear_regulator = next_out.buck_en[1];
    end
    // Pump during start-up wait, with any buck, or while awake
    next_out.charge_pump = !hard_off && (state == st_cp_wait || state == st_start_c ||
                           (|next_out.buck_en) || (state == st_run && sleep_ctrl_n));
    next_out.motor_oscillator = next_out.charge_pump && state == st_run;
    next_out.motor_en = state == st_run && !hard_off && !motor_stop && sleep_ctrl_n;
    next_reset_n = state == st_run && !hard_off && pulse_cnt == 24'h000000;
  end

  // Registered controls and reset output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwr_out                <= '0;
      power_good_reset_out_n <= 1'b0;
    end else begin
      pwr_out                <= next_out;
      power_good_reset_out_n <= next_reset_n;
    end
  end

  // Internal sleep held high until the sequencer reaches st_run
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_int_n <= 1'b1;
    end else if (state != st_run) begin
      sleep_int_n <= 1'b1;
    end else begin
      sleep_int_n <= sleep_ctrl_n;
    end
  end

  // ==========================================================================
  // Register bus
  assign wr_go  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign wr_ok  = !sleep_int_n;
  assign status = {setup_written, power_good_reset_out_n, sleep_int_n, hard_off,
                   motor_stop, lin_off, chan_off, pwr_out};

  // Address and data taken together in one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        if (s_axi_awaddr == ADDR_SETUP || s_axi_awaddr == ADDR_EXT) begin
          s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_awaddr == ADDR_STATUS) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_DECERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Setup registers; defaults on supply loss or clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      setup         <= SETUP_RESET;
      ext           <= EXT_RESET;
      setup_written <= 1'b0;
    end else if (soft_rst) begin
      setup         <= SETUP_RESET;
      ext           <= EXT_RESET;
      setup_written <= 1'b0;
    end else if (wr_go && wr_ok) begin
      if (s_axi_awaddr == ADDR_SETUP) begin
        setup         <= merge(setup, s_axi_wdata, s_axi_wstrb);
        setup_written <= 1'b1;
      end else if (s_axi_awaddr == ADDR_EXT) begin
        ext <= merge(ext, s_axi_wdata, s_axi_wstrb);
      end
    end
  end

  // Read channel
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case (s_axi_araddr)
          ADDR_SETUP:  s_axi_rdata <= {16'h0000, setup};
          ADDR_EXT:    s_axi_rdata <= {16'h0000, ext};
          ADDR_STATUS: s_axi_rdata <= {16'h0000, status};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_DECERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : bps_sequencer

// *** verif/bps_host_model.sv ***
// Host controller model driving the clear and sleep pins of the sequencer.
module bps_host_model (
  // Clock
  input  wire logic       clk,
  // Requests from the bench
  input  wire logic       go,
  input  wire logic [9:0] clr_len,
  input  wire logic       sleep_req_n,
  // Pins toward the sequencer
  output logic            system_clear_in_n,
  output logic            sleep_ctrl_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] left_cnt = 10'h000; // Clear cycles still to hold low
  // ==========================================================================
  // Clear held low for the requested count, then released
  always @(posedge clk) begin
    if (go) left_cnt <= clr_len;
    else if (left_cnt != 10'h000) left_cnt <= left_cnt - 10'h001;
  end
  assign system_clear_in_n = (left_cnt == 10'h000); // Idle pin reads as released
  assign sleep_ctrl_n      = sleep_req_n;           // Sleep pin follows the host request
endmodule : bps_host_model

// *** verif/bps_sequencer_properties.sv ***
// Port-level checks of the buck power sequencer.
module bps_sequencer_properties import bps_pkg::*; (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Inputs watched
  input wire logic        system_clear_in_n,
  input wire logic        supply_above_lower,
  input wire logic        chan_a_inhibit,
  input wire logic        s_axi_bready,
  // Outputs watched
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire bps_out_type pwr_out,
  input wire logic        power_good_reset_out_n,
  input wire logic        sleep_int_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] clr_cnt; // Cycles with clear held low, saturating
  // ==========================================================================
  // Clear low counter, outlasts the deglitch window
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) clr_cnt <= 9'h000;
    else if (system_clear_in_n) clr_cnt <= 9'h000;
    else if (clr_cnt != 9'h1ff) clr_cnt <= clr_cnt + 9'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Assertions
  a_clear_all_off: assert property (clr_cnt > 9'h0fe |-> pwr_out.buck_en == 3'h0 && !power_good_reset_out_n)
    else $error("regulator or reset output active during clear");
  a_inhibit_a_off: assert property (chan_a_inhibit [*3] |-> !pwr_out.buck_en[0])
    else $error("channel A on while inhibited");
  a_supply_off: assert property (!supply_above_lower [*3] |=> pwr_out.buck_en == 3'h0)
    else $error("buck on below lower threshold");
  a_lin_track: assert property (sleep_int_n && !power_good_reset_out_n |-> pwr_out.linear_regulator == pwr_out.buck_en[1])
    else $error("linear enable differs from B during power-up");
  a_pump_first: assert property ($rose(pwr_out.charge_pump) && sleep_int_n |-> (pwr_out.buck_en == 3'h0) [*8])
    else $error("buck started without pump wait");
  a_sleep_release: assert property ($fell(sleep_int_n) |-> power_good_reset_out_n)
    else $error("internal sleep dropped before reset output release");
  a_write_resp: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("write response missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
endmodule : bps_sequencer_properties

bind bps_sequencer bps_sequencer_properties u_props (.clk(clk), .rstn(rstn), .system_clear_in_n(system_clear_in_n),
  .supply_above_lower(supply_above_lower), .chan_a_inhibit(chan_a_inhibit), .s_axi_bready(s_axi_bready),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp), .pwr_out(pwr_out),
  .power_good_reset_out_n(power_good_reset_out_n), .sleep_int_n(sleep_int_n));

// *** verif/bps_sequencer_tb_top.sv ***
// Self-checking bench for the buck power sequencer.
module bps_sequencer_tb_top import bps_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk = 1'b0, rstn = 1'b0, go = 1'b0;         // Clock, reset, clear request
  logic [3:0]    awaddr = 4'h0, araddr = 4'h0, strb = 4'hf;   // Bus addresses
  logic [31:0]   wdata = 32'h0, rdata, lfsr_q = 32'ha826af67; // Bus data, random state
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic          awready, bvalid, arready, rvalid, pg_n, slp_n, clr_n, sleep_n;
  logic [1:0]    bresp, rresp, sel = SEL_GND;
  logic          up = 1'b0, low = 1'b0, inh = 1'b0, sreq = 1'b1; // Supply comparators, inhibit, sleep
  logic [9:0]    clr_len = 10'h000;
  logic [2:0]    en_q = 3'h0;                                 // Previous buck enables
  bps_fault_type faults = '0;
  bps_out_type   pwr;
  int            error_cnt = 0, checked = 0, cyc = 0, b_t = 0, c_t = 0, pg_t, up_t;
  bps_sequencer #(.CP_WAIT_N(20), .C_DELAY_N(20), .PG_REG_N(40), .PG_GND_N(50), .PULSE_N(30)) dut (
    .clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .supply_above_upper(up), .supply_above_lower(low), .start_select_pin(sel), .system_clear_in_n(clr_n),
    .sleep_ctrl_n(sleep_n), .chan_a_inhibit(inh), .faults(faults), .pwr_out(pwr), .power_good_reset_out_n(pg_n),
    .sleep_int_n(slp_n));
  bps_host_model host (.clk(clk), .go(go), .clr_len(clr_len), .sleep_req_n(sreq), .system_clear_in_n(clr_n),
    .sleep_ctrl_n(sleep_n));
  always #10 clk = ~clk;
  // Cycle count and rise times of channels B and C
  always @(posedge clk) begin
    cyc <= cyc + 1;
    en_q <= pwr.buck_en;
    if (pwr.buck_en[1] && !en_q[1]) b_t <= cyc;
    if (pwr.buck_en[2] && !en_q[2]) c_t <= cyc;
  end
  // ==========================================================================
  // Expectations and helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [3:0] exp_en(input logic [1:0] s); // Linear, C, B, A after power-up
    return (s == SEL_OPEN) ? 4'h6 : (s == SEL_PULLDOWN) ? 4'h2 : 4'h0;
  endfunction : exp_en
  function automatic logic [3:0] exp_set(input logic [31:0] d, input logic ih); // Enables from setup bits
    return {d[10], d[9], d[8], ~d[7] & ~ih};
  endfunction : exp_set
  function automatic logic sig(input int w);
    case (w)
      0: return awready;
      1: return bvalid;
      2: return arready;
      3: return rvalid;
      default: return pg_n;
    endcase
  endfunction : sig
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task tally_and_finish;
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Bounded wait for a handshake or the reset output
  task wait_for(input int w, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sig(w) !== 1'b1 && n < lim);
    if (sig(w) !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : wait_for
  task wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    wait_for(0, 20);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    wait_for(1, 20);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    wait_for(2, 20);
    arvalid <= 1'b0;
    rready <= 1'b1;
    wait_for(3, 20);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // Supply rise, a blocked early write, then wait for reset release
  task pwr_up(input logic [1:0] s);
    logic [1:0] r;
    sel <= s;
    up <= 1'b1;
    low <= 1'b1;
    up_t = cyc;
    wr(ADDR_SETUP, 32'h0000_0700, r);
    chk("early_wr", r, RESP_SLVERR);
    wait_for(4, 400);
    pg_t = cyc;
    repeat (4) @(posedge clk);
  endtask : pwr_up
  task clr(input logic [9:0] n);
    clr_len <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (n + 20) @(posedge clk);
  endtask : clr
  // ==========================================================================
  // Main sequence
  initial begin
    logic [1:0]  r;
    logic [31:0] d;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      pwr_up(2'(i));
      chk("en_up", {pwr.linear_regulator, pwr.buck_en}, exp_en(2'(i)));
      if (i == 0) chk("pg_gnd", (pg_t - up_t) inside {[50:56]}, 1'b1);
      if (i == 2) chk("c_delay", (c_t - b_t) inside {[19:21]}, 1'b1);
      up <= 1'b0;
      low <= 1'b0;
      repeat (4) @(posedge clk);
      chk("buck_off", pwr.buck_en, 3'h0);
    end
    pwr_up(SEL_OPEN);
    clr(10'h064);
    chk("glitch", pwr.buck_en, 3'h6);
    clr(10'h12c);
    chk("clr_off", {pwr.buck_en, pg_n}, 4'h0);
    wait_for(4, 800);
    repeat (4) @(posedge clk);
    chk("restart", pwr.buck_en, 3'h6);
    rd(ADDR_SETUP, d, r);
    chk("setup_rst", d, {16'h0, SETUP_RESET});
    rd(4'hc, d, r);
    chk("unmapped", r, RESP_DECERR);
    sreq <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr(lfsr_q);
      d = (i == 0) ? 32'h0000_0300 : {21'h0, lfsr_q[10:7], 7'h00};
      inh <= (i == 0) ? 1'b0 : lfsr_q[3];
      strb <= {lfsr_q[5:4], 2'h3};
      wr(ADDR_SETUP, d, r);
      chk("wr_ok", r, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("en_set", {pwr.linear_regulator, pwr.buck_en}, exp_set(d, inh));
    end
    wr(ADDR_SETUP, 32'h0000_0700, r);
    faults.buck_oc <= 3'h2;
    repeat (4) @(posedge clk);
    chk("fault_off", {pwr.buck_en, pg_n}, 4'h0);
    faults <= '0;
    tally_and_finish();
  end
endmodule : bps_sequencer_tb_top
